// file: design/pad_configuration_mux_regs.svh
// register offsets, field positions, reset values and timing for the pad configuration block
`ifndef PAD_CONFIGURATION_MUX_REGS_SVH
`define PAD_CONFIGURATION_MUX_REGS_SVH

`define PCM_NUM_PINS        12
`define PCM_ADDR_W          6
// pin config words 0x00..0x2c, one per pin
`define PCM_PINCFG_BASE     6'h00
`define PCM_DIR_ADDR        6'h30
`define PCM_PADIN_ADDR      6'h34
`define PCM_PWR_ADDR        6'h38
// pin config fields
`define PCM_PIN_FUNCTION_SELECT_LSB        0
`define PCM_MODE_LSB        3
`define PCM_HYS_BIT         5
`define PCM_INV_BIT         6
`define PCM_FILT_BIT        7
`define PCM_I2C_BIT         8
`define PCM_ANA_BIT         9
`define PCM_ILO_LSB         10
`define PCM_IHI_LSB         14
`define PCM_CFG_W           18
`define PCM_PIN_FUNCTION_SELECT_GPIO       3'h0
`define PCM_MODE_NONE       2'h0
`define PCM_CFG_RESET       18'h00000
`define PCM_PWR_DPD_BIT     0
// pin indices of the special pads
`define PCM_I2C_SCL_PIN     4
`define PCM_I2C_SDA_PIN     5
`define PCM_HS_PIN_A        3
`define PCM_HS_PIN_B        7
`define PCM_HS_PIN_C        10
`define PCM_HS_PIN_D        11
// glitch filter time: 50 ns at 100 MHz
`define PCM_FILT_NS         50
`define PCM_CLK_MHZ         100
`define PCM_FILT_CYC        ((`PCM_FILT_NS * `PCM_CLK_MHZ) / 1000)

`endif

// file: design/pad_configuration_mux_pkg.sv
// types shared by the pad configuration block
package pad_configuration_mux_pkg;

   typedef enum logic [1:0] {mode_none, mode_pull_down, mode_pull_up, mode_repeater} res_mode_t;

   typedef struct packed {
      logic [3:0] high_current_level;
      logic [3:0] low_current_level;
      logic       analog_sink;
      logic       i2c_std;
      logic       filter_en;
      logic       invert;
      logic       hysteresis;
      res_mode_t  res_mode;
      logic [2:0] pin_function_select;
   } pin_cfg_t;

   typedef struct packed {
      logic       out;
      logic       oe;
      logic       pull_up;
      logic       pull_down;
      logic       hysteresis;
      logic       filter_en;
      logic       analog_sink;
      logic [3:0] sink_level;
   } pad_ctrl_t;

endpackage

// file: design/pad_configuration_mux.sv
// pad configuration block: function select, direction, resistors, filters, current sink
//
// Function
// - function field 000 routes the general-purpose port; others route a peripheral.
// - in general-purpose mode the direction register bit sets pad direction.
// - peripheral mode takes direction from the peripheral, ignoring the direction bit.
// - resistor mode chooses pull-up, pull-down, none or repeater.
// - after reset every resistor mode is none.
// - repeater drives pull matching the pin level, keeping an undriven input's level.
// - repeater retention is dropped in deep power-down.
// - config also sets input mode, hysteresis, low-pass filter and keeper option.
// - serial-bus pads offer filtered standard/fast mode with open-drain output.
// - alternative serial-bus setting: plain open-drain with the digital low-pass filter bypassed.
// - four high-source pads select digital drive or analog current sink.
// - current sink switches between the low and high current level fields.
//
// The register offsets and the plain strobed port were decided locally.
`include "pad_configuration_mux_regs.svh"

module pad_configuration_mux
(
   input  wire logic                          core_clk_i,   // system clock 100 MHz
   input  wire logic                          rst_n_i,      // sync reset, active low
   input  wire logic [`PCM_ADDR_W-1:0]        addr_i,       // register byte address
   input  wire logic [31:0]                   wdata_i,      // write data
   input  wire logic                          wr_i,         // write strobe
   input  wire logic                          rd_i,         // read strobe
   output logic      [31:0]                   rdata_o,      // read data, cycle after rd_i
   input  wire logic [`PCM_NUM_PINS-1:0]      gpio_out_i,   // port output values
   input  wire logic [`PCM_NUM_PINS-1:0]      periph_out_i, // peripheral output values
   input  wire logic [`PCM_NUM_PINS-1:0]      periph_oe_i,  // peripheral direction needs
   output logic      [`PCM_NUM_PINS-1:0]      pad_in_o,     // conditioned pad input to core
   input  wire logic [`PCM_NUM_PINS-1:0]      pad_i,        // pad level from pin
   output logic      [`PCM_NUM_PINS-1:0]      pad_o,        // pad output level
   output logic      [`PCM_NUM_PINS-1:0]      pad_oe_o,     // pad output enable
   output logic      [`PCM_NUM_PINS-1:0]      pad_pu_o,     // pull-up enable
   output logic      [`PCM_NUM_PINS-1:0]      pad_pd_o,     // pull-down enable
   output logic      [`PCM_NUM_PINS-1:0]      pad_hys_o,    // hysteresis enable
   output logic      [`PCM_NUM_PINS-1:0]      pad_filt_o,   // analog glitch filter enable
   output logic      [`PCM_NUM_PINS-1:0]      pad_sink_o,   // analog current sink mode
   output logic      [4*`PCM_NUM_PINS-1:0]    pad_sink_lvl_o // sink current code per pin
);

   localparam int N = `PCM_NUM_PINS;
   localparam int FCYC = (`PCM_FILT_CYC < 1) ? 1 : `PCM_FILT_CYC;

   pad_configuration_mux_pkg::pin_cfg_t  cfg [N];
   pad_configuration_mux_pkg::pad_ctrl_t next_ctrl [N];
   logic [N-1:0] port_direction_reg;
   logic         deep_pdn;
   logic [N-1:0] pad_s1;
   logic [N-1:0] pad_s2;
   logic [N-1:0] pad_filt;
   logic [2:0]   filt_cnt [N];

   // true for the four high-source pads
   function automatic logic is_high_source(input int p);
      return (p == `PCM_HS_PIN_A) || (p == `PCM_HS_PIN_B) || (p == `PCM_HS_PIN_C) || (p == `PCM_HS_PIN_D);
   endfunction

   // true for the two serial-bus pads
   function automatic logic is_i2c_pad(input int p);
      return (p == `PCM_I2C_SCL_PIN) || (p == `PCM_I2C_SDA_PIN);
   endfunction

   // true when the address selects pin p's configuration word
   // shared by the write and read decode so both agree on the map
   function automatic logic cfg_hit(input logic [`PCM_ADDR_W-1:0] a, input int p);
      return a == (`PCM_PINCFG_BASE + `PCM_ADDR_W'(4 * p));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   // writes take effect at the strobe edge; the pad controls follow one
   // edge later, so software sees a setting on the pad two edges after
   // the strobe. unmapped addresses are ignored and never stall the bus.

   // pin configuration words
   // only the low configuration bits are kept; upper write bits are dropped
   always_ff @(posedge core_clk_i)
   begin
      for (int p = 0; p < N; p++)
      begin
         if (!rst_n_i)
            cfg[p] <= `PCM_CFG_RESET;
         else if (wr_i && cfg_hit(addr_i, p))
            cfg[p] <= wdata_i[`PCM_CFG_W-1:0];
      end
   end

   // direction register
   // resets to all inputs so no pad drives before software decides
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         port_direction_reg <= '0;
      else if (wr_i && (addr_i == `PCM_DIR_ADDR))
         port_direction_reg <= wdata_i[N-1:0];
   end

   // deep power-down flag
   // only gates the repeater pulls here; power sequencing lives elsewhere
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         deep_pdn <= 1'b0;
      else if (wr_i && (addr_i == `PCM_PWR_ADDR))
         deep_pdn <= wdata_i[`PCM_PWR_DPD_BIT];
   end

   // read data, one cycle later
   // returns zero outside the read cycle so a stale word never lingers
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         rdata_o <= 32'h00000000;
      else if (rd_i)
      begin
         rdata_o <= 32'h00000000;
         if (addr_i == `PCM_DIR_ADDR)
            rdata_o[N-1:0] <= port_direction_reg;
         else if (addr_i == `PCM_PADIN_ADDR)
            rdata_o[N-1:0] <= pad_in_o;
         else if (addr_i == `PCM_PWR_ADDR)
            rdata_o[`PCM_PWR_DPD_BIT] <= deep_pdn;
         else
            for (int p = 0; p < N; p++)
               if (cfg_hit(addr_i, p))
                  rdata_o[`PCM_CFG_W-1:0] <= cfg[p];
      end
      else
         rdata_o <= 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad input path

   // two-flop synchroniser of pad levels
   // pins are asynchronous; nothing but the second stage reads the first
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         pad_s1 <= '0;
         pad_s2 <= '0;
      end
      else
      begin
         pad_s1 <= pad_i;
         pad_s2 <= pad_s1;
      end
   end

   // digital low-pass: level must hold FCYC cycles
   // any bounce back to the filtered level restarts the count, so short
   // spikes on a serial line in standard/fast mode never reach the core
   always_ff @(posedge core_clk_i)
   begin
      for (int p = 0; p < N; p++)
      begin
         if (!rst_n_i)
         begin
            pad_filt[p] <= 1'b0;
            filt_cnt[p] <= 3'h0;
         end
         else if (pad_s2[p] == pad_filt[p])
            filt_cnt[p] <= 3'h0;
         else if (filt_cnt[p] >= 3'(FCYC - 1))
         begin
            pad_filt[p] <= pad_s2[p];
            filt_cnt[p] <= 3'h0;
         end
         else
            filt_cnt[p] <= filt_cnt[p] + 3'h1;
      end
   end

   // conditioned input with optional filter and inversion
   // inversion sits after the filter so the filter sees true pin levels
   always_ff @(posedge core_clk_i)
   begin
      for (int p = 0; p < N; p++)
      begin
         if (!rst_n_i)
            pad_in_o[p] <= 1'b0;
         else if (is_i2c_pad(p) && (cfg[p].pin_function_select != `PCM_PIN_FUNCTION_SELECT_GPIO) && !cfg[p].i2c_std)
            pad_in_o[p] <= pad_s2[p] ^ cfg[p].invert;
         else if (cfg[p].filter_en || (is_i2c_pad(p) && cfg[p].i2c_std))
            pad_in_o[p] <= pad_filt[p] ^ cfg[p].invert;
         else
            pad_in_o[p] <= pad_s2[p] ^ cfg[p].invert;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad control decode
   // everything below is decoded fresh each cycle from the stored fields
   // and the peripheral requests; the output flops then hold the result,
   // which keeps pad control glitch-free toward the pins

   // per-pin next pad controls
   always_comb
   begin
      for (int p = 0; p < N; p++)
      begin
         next_ctrl[p] = '0;
         if (cfg[p].pin_function_select == `PCM_PIN_FUNCTION_SELECT_GPIO)
         begin
            next_ctrl[p].out = gpio_out_i[p];
            next_ctrl[p].oe = port_direction_reg[p];
         end
         else
         begin
            next_ctrl[p].out = periph_out_i[p];
            next_ctrl[p].oe = periph_oe_i[p];
            // serial-bus open-drain drive
            // the pad only ever pulls low; a high level comes from the bus
            if (is_i2c_pad(p))
            begin
               next_ctrl[p].oe = periph_oe_i[p] && !periph_out_i[p];
               next_ctrl[p].out = 1'b0;
            end
         end
         case (cfg[p].res_mode)
            pad_configuration_mux_pkg::mode_pull_up:
               next_ctrl[p].pull_up = 1'b1;
            pad_configuration_mux_pkg::mode_pull_down:
               next_ctrl[p].pull_down = 1'b1;
            pad_configuration_mux_pkg::mode_repeater:
            begin
               next_ctrl[p].pull_up = !deep_pdn && pad_s2[p];
               next_ctrl[p].pull_down = !deep_pdn && !pad_s2[p];
            end
            default:
            begin
               next_ctrl[p].pull_up = 1'b0;
               next_ctrl[p].pull_down = 1'b0;
            end
         endcase
         next_ctrl[p].hysteresis = cfg[p].hysteresis;
         next_ctrl[p].filter_en = cfg[p].filter_en || (is_i2c_pad(p) && cfg[p].i2c_std);
         // current sink on high-source pads
         // the sink bit is ignored on other pins, which have no sink stage
         if (is_high_source(p) && cfg[p].analog_sink)
         begin
            next_ctrl[p].analog_sink = 1'b1;
            next_ctrl[p].oe = 1'b1;
            next_ctrl[p].sink_level = next_ctrl[p].out ? cfg[p].high_current_level : cfg[p].low_current_level;
         end
      end
   end

   // registered pad controls
   // reset leaves every pad an undriven input with no pull
   always_ff @(posedge core_clk_i)
   begin
      for (int p = 0; p < N; p++)
      begin
         if (!rst_n_i)
         begin
            pad_o[p] <= 1'b0;
            pad_oe_o[p] <= 1'b0;
            pad_pu_o[p] <= 1'b0;
            pad_pd_o[p] <= 1'b0;
            pad_hys_o[p] <= 1'b0;
            pad_filt_o[p] <= 1'b0;
            pad_sink_o[p] <= 1'b0;
            pad_sink_lvl_o[4*p +: 4] <= 4'h0;
         end
         else
         begin
            pad_o[p] <= next_ctrl[p].out;
            pad_oe_o[p] <= next_ctrl[p].oe;
            pad_pu_o[p] <= next_ctrl[p].pull_up;
            pad_pd_o[p] <= next_ctrl[p].pull_down;
            pad_hys_o[p] <= next_ctrl[p].hysteresis;
            pad_filt_o[p] <= next_ctrl[p].filter_en;
            pad_sink_o[p] <= next_ctrl[p].analog_sink;
            pad_sink_lvl_o[4*p +: 4] <= next_ctrl[p].sink_level;
         end
      end
   end

endmodule

// file: verification/pad_configuration_mux_monitor.sv
// port-level checks for the pad configuration block
`include "pad_configuration_mux_regs.svh"
module pad_configuration_mux_monitor
(
   input wire logic        core_clk_i,    // clock
   input wire logic        rst_n_i,       // reset, low
   input wire logic [5:0]  addr_i,        // address
   input wire logic [31:0] wdata_i,       // write data
   input wire logic        wr_i,          // write strobe
   input wire logic [11:0] gpio_out_i,    // port values
   input wire logic [11:0] periph_out_i,  // periph values
   input wire logic [11:0] periph_oe_i,   // periph drive
   input wire logic [11:0] pad_i,         // pin level
   input wire logic [11:0] pad_o,         // pad out
   input wire logic [11:0] pad_oe_o,      // pad enable
   input wire logic [11:0] pad_pu_o,      // pull-up
   input wire logic [11:0] pad_pd_o,      // pull-down
   input wire logic [11:0] pad_sink_o,    // sink mode
   input wire logic [47:0] pad_sink_lvl_o // sink code
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [17:0] cfg [12];
   logic [11:0] dir;
   logic        dpd;
   logic        out0;
   logic        od4;
   logic [3:0]  lvl3;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   // shadow of what software wrote
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg <= '{default: 18'h00000};
         dir <= 12'h000;
         dpd <= 1'b0;
      end
      else if (wr_i)
      begin
         if (addr_i == `PCM_DIR_ADDR)
            dir <= wdata_i[11:0];
         if (addr_i == `PCM_PWR_ADDR)
            dpd <= wdata_i[0];
         if (addr_i < `PCM_DIR_ADDR && addr_i[1:0] == 2'h0)
            cfg[addr_i[5:2]] <= wdata_i[17:0];
      end
   end
   // expected pad values one cycle ahead
   assign out0 = (cfg[0][2:0] == 3'h0) ? gpio_out_i[0] : periph_out_i[0];
   assign od4 = periph_oe_i[4] & ~periph_out_i[4];
   assign lvl3 = gpio_out_i[3] ? cfg[3][17:14] : cfg[3][13:10];
   sequence rep_hold;
      (cfg[1][4:3] == 2'h3 && !dpd && $stable(pad_i[1])) [*6];
   endsequence
   ////////////////////////////////////////
   a_gpio_dir: assert property (cfg[0][2:0] == 3'h0 |=> pad_oe_o[0] == $past(dir[0]))
      else $error("port pin direction wrong");
   a_out_select: assert property ((cfg[0][2:0] == 3'h0 ? dir[0] : periph_oe_i[0]) |=> pad_o[0] == $past(out0))
      else $error("pad output source wrong");
   a_pull_up: assert property (cfg[1][4:3] == 2'h2 |=> pad_pu_o[1] && !pad_pd_o[1])
      else $error("pull-up mode wrong");
   a_reset_quiet: assert property ($rose(rst_n_i) |-> (pad_pu_o | pad_pd_o | pad_oe_o) == 12'h000)
      else $error("pad controls active after reset");
   a_repeater_follow: assert property (rep_hold |=> pad_pu_o[1] == $past(pad_i[1]) && pad_pd_o[1] == !$past(pad_i[1]))
      else $error("repeater pull does not follow pin");
   a_dpd_release: assert property (dpd && cfg[1][4:3] == 2'h3 |=> !pad_pu_o[1] && !pad_pd_o[1])
      else $error("repeater active in deep power-down");
   a_open_drain: assert property (cfg[4][2:0] != 3'h0 |=> !pad_o[4] && pad_oe_o[4] == $past(od4))
      else $error("serial pad not open-drain");
   a_sink_level: assert property (cfg[3][9] && cfg[3][2:0] == 3'h0 |=> pad_sink_o[3] && pad_sink_lvl_o[15:12] == $past(lvl3))
      else $error("sink level wrong");
endmodule

// file: verification/pad_partner.sv
// pin-side model: outside drivers, pulls and floating lines
module pad_partner
(
   input wire logic        core_clk_i, // clock for float pattern
   input wire logic [11:0] dev_out_i,  // device drive level
   input wire logic [11:0] dev_oe_i,   // device drive enable
   input wire logic [11:0] pull_up_i,  // pull-up on
   input wire logic [11:0] pull_dn_i,  // pull-down on
   input wire logic [11:0] ext_en_i,   // outside driver on
   input wire logic [11:0] ext_val_i,  // outside level
   output logic     [11:0] level_o     // resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] drift = 12'h5a5;
   // an undriven, unpulled pin wanders every cycle
   always @(posedge core_clk_i)
      drift <= ~drift;
   // resolve each pin from its drivers
   always_comb
   begin
      for (int p = 0; p < 12; p++)
      begin
         if (ext_en_i[p])
            level_o[p] = ext_val_i[p];
         else if (dev_oe_i[p])
            level_o[p] = dev_out_i[p];
         else if (pull_up_i[p] | pull_dn_i[p])
            level_o[p] = pull_up_i[p];
         else
            level_o[p] = drift[p];
      end
   end
endmodule

// file: verification/pad_configuration_mux_test.sv
// self-checking bench for the pad configuration block
`include "pad_configuration_mux_regs.svh"
module pad_configuration_mux_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [5:0]  addr_i = 6'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic [11:0] gpio_out_i = 12'h000, periph_out_i = 12'h000, periph_oe_i = 12'h000, ext_en = 12'h000;
   logic [11:0] ext_val = 12'h000, pad_i, pad_in_o, pad_o, pad_oe_o, pad_pu_o, pad_pd_o, pad_hys_o;
   logic [11:0] pad_filt_o, pad_sink_o;
   logic [47:0] pad_sink_lvl_o;
   int          errors = 0, num_checks = 0;
   pad_configuration_mux i_pad_configuration_mux (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .gpio_out_i, .periph_out_i, .periph_oe_i, .pad_in_o, .pad_i, .pad_o, .pad_oe_o, .pad_pu_o, .pad_pd_o,
      .pad_hys_o, .pad_filt_o, .pad_sink_o, .pad_sink_lvl_o);
   pad_partner i_pad_partner (.core_clk_i, .dev_out_i(pad_o), .dev_oe_i(pad_oe_o), .pull_up_i(pad_pu_o),
      .pull_dn_i(pad_pd_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_i));
   always #5 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // config word from function, resistor mode and the upper fields
   function automatic logic [31:0] cw(input logic [2:0] f, input logic [1:0] m, input logic [12:0] x);
      return (32'(f) << `PCM_PIN_FUNCTION_SELECT_LSB) | (32'(m) << `PCM_MODE_LSB) | (32'(x) << `PCM_HYS_BIT);
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #100000;
      errors++;
      conclude();
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int p = 0; p < 12; p++)
         rd(6'(4 * p), 32'h0);
      rd(6'h3c, 32'h0);
      gpio_out_i <= 12'ha5c;
      wr(`PCM_DIR_ADDR, 32'h00000fff);
      settle(1);
      chk({pad_oe_o, pad_o}, {12'hfff, 12'ha5c});
      rd(`PCM_DIR_ADDR, 32'h00000fff);
      // every peripheral code overrides the direction bit
      periph_oe_i <= 12'h012;
      periph_out_i <= 12'h001;
      for (int f = 1; f < 8; f++)
      begin
         wr(6'h00, cw(3'(f), 2'h0, 13'h0000));
         settle(1);
         chk(pad_oe_o[0], 1'b0);
      end
      periph_oe_i <= 12'h013;
      wr(`PCM_DIR_ADDR, 32'h0);
      settle(1);
      chk({pad_oe_o[0], pad_o[0]}, 2'b11);
      // resistor modes on pin 1
      for (int m = 0; m < 3; m++)
      begin
         wr(6'h04, cw(3'h0, 2'(m), 13'h0000));
         settle(1);
         chk({pad_pu_o[1], pad_pd_o[1]}, {m == 2, m == 1});
      end
      for (int v = 1; v >= 0; v--)
      begin
         ext_val <= 12'(v << 1);
         ext_en <= 12'h002;
         wr(6'h04, cw(3'h0, 2'h3, 13'h0000));
         settle(8);
         ext_en <= 12'h000;
         settle(10);
         chk({pad_pu_o[1], pad_pd_o[1], pad_in_o[1]}, {v == 1, v == 0, v == 1});
      end
      rd(6'h04, cw(3'h0, 2'h3, 13'h0000));
      wr(`PCM_PWR_ADDR, 32'h1);
      rd(`PCM_PWR_ADDR, 32'h1);
      chk({pad_pu_o[1], pad_pd_o[1]}, 2'b00);
      wr(`PCM_PWR_ADDR, 32'h0);
      // hysteresis, invert and filter on pin 2
      ext_val <= 12'h004;
      ext_en <= 12'h004;
      wr(6'h08, cw(3'h0, 2'h0, 13'h0007));
      settle(12);
      chk({pad_hys_o[2], pad_filt_o[2], pad_in_o[2]}, 3'b110);
      // serial pad in both bus settings
      for (int b = 0; b < 2; b++)
      begin
         periph_out_i <= 12'h001;
         wr(6'h10, cw(3'h1, 2'h0, 13'(b << 3)));
         settle(1);
         chk({pad_oe_o[4], pad_o[4]}, 2'b10);
         chk(pad_filt_o[4], 48'(b));
         periph_out_i <= 12'h011;
         settle(2);
         chk(pad_oe_o[4], 1'b0);
      end
      // current sink on pin 3
      wr(6'h0c, cw(3'h0, 2'h0, 13'h1870));
      settle(1);
      chk({pad_sink_o[3], pad_oe_o[3], pad_sink_lvl_o[15:12]}, 6'h3c);
      gpio_out_i <= 12'ha54;
      settle(2);
      chk({pad_sink_o[3], pad_oe_o[3], pad_sink_lvl_o[15:12]}, 6'h33);
      conclude();
   end
endmodule
bind pad_configuration_mux pad_configuration_mux_monitor i_pad_configuration_mux_monitor (.core_clk_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .gpio_out_i, .periph_out_i, .periph_oe_i, .pad_i, .pad_o, .pad_oe_o, .pad_pu_o,
   .pad_pd_o, .pad_sink_o, .pad_sink_lvl_o);
